// ===== src/aft_pkg.sv
// Constants, types and helpers for the storage function config and cable timing bank.
// Assumes byte addressed config space carried as aligned dwords with byte enables.
package aft_pkg;
   // Register byte offsets; bits 7:2 pick the dword, bits 1:0 the lane
   localparam logic [7:0]  OFF_SUBSYSTEM_VENDOR_IDENT     = 8'h2c;
   localparam logic [7:0]  OFF_SID      = 8'h2e;
   localparam logic [7:0]  OFF_CAP      = 8'h34;
   localparam logic [7:0]  OFF_IRQ_ROUTING_LINE   = 8'h3c;
   localparam logic [7:0]  OFF_IRQ_PIN_SELECT   = 8'h3d;
   localparam logic [7:0]  OFF_PRI_TIM  = 8'h40;
   localparam logic [7:0]  OFF_SEC_TIM  = 8'h42;
   // Reset and constant values
   localparam logic [15:0] RST_SUBSYSTEM_VENDOR_IDENT     = 16'h0000;
   localparam logic [15:0] RST_SID      = 16'h0000;
   localparam logic [7:0]  VAL_CAP      = 8'h00;
   localparam logic [7:0]  RST_IRQ_ROUTING_LINE   = 8'h00;
   localparam logic [7:0]  VAL_IRQ_PIN_SELECT   = 8'h01;
   localparam logic [15:0] RST_TIM      = 16'h0000;
   localparam logic [15:0] TIM_WMASK    = 16'hf3ff;
   // Cable timing register fields
   localparam int TB_DEC_EN = 15;
   localparam int TB_SEP    = 14;
   localparam int TB_ISP_LO = 12;
   localparam int TB_RCT_LO = 8;
   localparam int TB_DMA1   = 7;
   localparam int TB_PF1    = 6;
   localparam int TB_IE1    = 5;
   localparam int TB_FAST1  = 4;
   localparam int TB_DMA0   = 3;
   localparam int TB_PF0    = 2;
   localparam int TB_IE0    = 1;
   localparam int TB_FAST0  = 0;
   // Separate drive 1 timing input fields
   localparam int SL_SISP_LO = 6;
   localparam int SL_SRCT_LO = 4;
   localparam int SL_PISP_LO = 2;
   localparam int SL_PRCT_LO = 0;
   // Clock counts
   localparam logic [2:0] ISP_CLKS_00 = 3'h5;
   localparam logic [2:0] ISP_CLKS_01 = 3'h4;
   localparam logic [2:0] ISP_CLKS_10 = 3'h3;
   localparam logic [2:0] RCT_CLKS_00 = 3'h4;
   localparam logic [2:0] RCT_CLKS_01 = 3'h3;
   localparam logic [2:0] RCT_CLKS_10 = 3'h2;
   localparam logic [2:0] RCT_CLKS_11 = 3'h1;
   localparam logic [2:0] COMPAT_ISP  = 3'h6;
   localparam logic [2:0] COMPAT_RCT  = 3'h5;
   // Legacy decode ranges
   localparam logic [15:0] PRI_CMD_BASE = 16'h01f0;
   localparam logic [15:0] SEC_CMD_BASE = 16'h0170;
   localparam logic [15:0] PRI_CTL_PORT = 16'h03f6;
   localparam logic [15:0] SEC_CTL_PORT = 16'h0376;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_STROBE = 2'b01,
      ST_WAIT   = 2'b10,
      ST_RECOV  = 2'b11
   } aft_state_t;

   // Reserved code 11 falls back to the shortest legal delay
   function automatic logic [2:0] isp_clks(input logic [1:0] code);
      isp_clks = (code == 2'h0) ? ISP_CLKS_00 :
                 (code == 2'h1) ? ISP_CLKS_01 : ISP_CLKS_10;
   endfunction

   function automatic logic [2:0] rct_clks(input logic [1:0] code);
      rct_clks = (code == 2'h0) ? RCT_CLKS_00 :
                 (code == 2'h1) ? RCT_CLKS_01 :
                 (code == 2'h2) ? RCT_CLKS_10 : RCT_CLKS_11;
   endfunction
endpackage

// ===== src/aft_tim_if.sv
// Resolved cable timing for one channel and one access.
// Produced by the channel timing decoder, consumed by the cycle engine.
`timescale 1ns/1ps
interface aft_tim_if;
   logic [2:0] sample_clks;
   logic [2:0] recov_clks;
   logic       iordy_en;
   logic       prefetch_en;
   logic       fast;
   modport prod (output sample_clks, recov_clks, iordy_en, prefetch_en, fast);
   modport cons (input sample_clks, recov_clks, iordy_en, prefetch_en, fast);
endinterface

// ===== src/aft_once_reg.sv
// Sixteen bit register that takes its first write and then locks.
// Assumes the caller raises i_wr only on writes that hit this register.
`timescale 1ns/1ps
module aft_once_reg
   import aft_pkg::*;
#(
   parameter logic [15:0] RESET_VAL = 16'h0000
) (
   // Clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_sys_rst,
   // Write side
   input  wire logic        i_wr,
   input  wire logic [1:0]  i_be,
   input  wire logic [15:0] i_wdata,
   // Stored value
   output logic [15:0]      o_value,
   output logic             o_locked
);
   logic [15:0] value_ff;
   logic        lock_ff;
   wire         take = i_wr && !lock_ff && (i_be != 2'h0);
   wire [15:0]  lane = {{8{i_be[1]}}, {8{i_be[0]}}};
   wire [15:0]  nxt_value = take ? ((value_ff & ~lane) | (i_wdata & lane)) : value_ff;

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         value_ff <= RESET_VAL;
         lock_ff  <= 1'b0;
      end else begin
         value_ff <= nxt_value;
         lock_ff  <= lock_ff || take;
      end
   end

   assign o_value  = value_ff;
   assign o_locked = lock_ff;

   property p_once_hold;
      @(posedge i_clock) disable iff (i_sys_rst)
      (lock_ff && i_wr) |=> $stable(value_ff);
   endproperty
   a_once_hold: assert property (p_once_hold) else $error("locked value changed");

   property p_once_lock;
      @(posedge i_clock) disable iff (i_sys_rst)
      (i_wr && i_be != 2'h0) |=> lock_ff;
   endproperty
   a_once_lock: assert property (p_once_lock) else $error("lock not set on write");
endmodule

// ===== src/aft_chan_timing.sv
// Resolves one channel's timing register into counts for one access.
// Assumes the separate drive 1 fields come from the slave timing register outside.
`timescale 1ns/1ps
module aft_chan_timing
   import aft_pkg::*;
(
   // Channel settings
   input  wire logic [15:0] i_timing,
   input  wire logic [1:0]  i_slave_isp,
   input  wire logic [1:0]  i_slave_rct,
   // Access kind
   input  wire logic        i_drive,
   input  wire logic        i_dma,
   input  wire logic        i_data_port,
   // Result
   aft_tim_if.prod          o_tim
);
   wire dma_fast  = i_drive ? i_timing[TB_DMA1]  : i_timing[TB_DMA0];
   wire pf_en     = i_drive ? i_timing[TB_PF1]   : i_timing[TB_PF0];
   wire rdy_en    = i_drive ? i_timing[TB_IE1]   : i_timing[TB_IE0];
   wire fast_bank = i_drive ? i_timing[TB_FAST1] : i_timing[TB_FAST0];
   // PIO keeps compatible timing unless the fast bank is chosen for the data port
   wire use_fast  = i_dma ? dma_fast : (i_data_port && fast_bank);
   wire use_slave = i_drive && i_timing[TB_SEP];
   wire [1:0] isp_code = use_slave ? i_slave_isp : i_timing[TB_ISP_LO +: 2];
   wire [1:0] rct_code = use_slave ? i_slave_rct : i_timing[TB_RCT_LO +: 2];

   assign o_tim.sample_clks = use_fast ? isp_clks(isp_code) : COMPAT_ISP;
   assign o_tim.recov_clks  = use_fast ? rct_clks(rct_code) : COMPAT_RCT;
   assign o_tim.iordy_en    = rdy_en;
   assign o_tim.prefetch_en = pf_en && i_data_port && !i_dma;
   assign o_tim.fast        = use_fast;
endmodule

// ===== src/aft_cfg_top.sv
// Config register bank and cable cycle timer of the storage host function.
// Assumes config cycles arrive as single-cycle dword accesses with byte enables,
// and that the drive 1 separate timing fields and BAR hits come from outside.
`timescale 1ns/1ps
module aft_cfg_top
   import aft_pkg::*;
(
   // Clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_sys_rst,
   // Configuration cycles
   input  wire logic        i_cfg_rd,
   input  wire logic        i_cfg_wr,
   input  wire logic [7:0]  i_cfg_addr,
   input  wire logic [3:0]  i_cfg_be,
   input  wire logic [31:0] i_cfg_wdata,
   output logic [31:0]      o_cfg_rdata,
   // Channel mode and shared settings
   input  wire logic [1:0]  i_native_mode,
   input  wire logic [7:0]  i_slave_timing,
   output logic             o_irq_pin_active,
   output logic [1:0]       o_decode_en,
   // I/O decode
   input  wire logic [15:0] i_io_addr,
   input  wire logic [1:0]  i_native_hit,
   output logic             o_pri_hit,
   output logic             o_sec_hit,
   // Cable cycle request
   input  wire logic        i_xfer_req,
   input  wire logic        i_xfer_chan,
   input  wire logic        i_xfer_drive,
   input  wire logic        i_xfer_dma,
   input  wire logic        i_xfer_data_port,
   input  wire logic        i_iordy,
   // Cable cycle status
   output logic             o_strobe,
   output logic             o_busy,
   output logic             o_xfer_done,
   output logic             o_xfer_refused,
   output logic             o_prefetch_en,
   output logic             o_fast_timing
);
   logic [15:0] pri_tim_ff;
   logic [15:0] sec_tim_ff;
   logic [7:0]  irq_line_ff;
   logic [31:0] rdata_ff;
   aft_state_t  state_ff;
   aft_state_t  nxt_state;
   logic [2:0]  cnt_ff;
   logic [2:0]  nxt_cnt;
   logic [2:0]  smp_ff;
   logic [2:0]  rec_ff;
   logic        rdy_en_ff;
   logic        pf_ff;
   logic        fast_ff;
   logic [15:0] subsystem_vendor_ident_val;
   logic [15:0] sid_val;
   logic        subsystem_vendor_ident_locked;
   logic        sid_locked;

   function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                           input logic [15:0] new_v,
                                           input logic [1:0]  be);
      logic [15:0] m;
      m = {{8{be[1]}}, {8{be[0]}}} & TIM_WMASK;
      merge16 = (old_v & ~m) | (new_v & m);
   endfunction

   // Dword decode of config cycles
   wire [5:0] dw       = i_cfg_addr[7:2];
   wire       hit_sub  = (dw == OFF_SUBSYSTEM_VENDOR_IDENT[7:2]);
   wire       hit_cap  = (dw == OFF_CAP[7:2]);
   wire       hit_int  = (dw == OFF_IRQ_ROUTING_LINE[7:2]);
   wire       hit_tim  = (dw == OFF_PRI_TIM[7:2]);
   wire [1:0] be_subsystem_vendor_ident  = i_cfg_be[OFF_SUBSYSTEM_VENDOR_IDENT[1:0] +: 2];
   wire [1:0] be_sid   = i_cfg_be[OFF_SID[1:0] +: 2];
   wire [1:0] be_pri   = i_cfg_be[OFF_PRI_TIM[1:0] +: 2];
   wire [1:0] be_sec   = i_cfg_be[OFF_SEC_TIM[1:0] +: 2];
   wire       be_line  = i_cfg_be[OFF_IRQ_ROUTING_LINE[1:0]];
   wire       wr_sub   = i_cfg_wr && hit_sub;
   wire       wr_tim   = i_cfg_wr && hit_tim;
   wire       wr_line  = i_cfg_wr && hit_int && be_line;
   wire [15:0] wd_subsystem_vendor_ident = i_cfg_wdata[8*OFF_SUBSYSTEM_VENDOR_IDENT[1:0] +: 16];
   wire [15:0] wd_sid  = i_cfg_wdata[8*OFF_SID[1:0] +: 16];
   wire [15:0] wd_pri  = i_cfg_wdata[8*OFF_PRI_TIM[1:0] +: 16];
   wire [15:0] wd_sec  = i_cfg_wdata[8*OFF_SEC_TIM[1:0] +: 16];
   wire [7:0]  wd_line = i_cfg_wdata[8*OFF_IRQ_ROUTING_LINE[1:0] +: 8];

   wire [15:0] nxt_pri_tim  = wr_tim ? merge16(pri_tim_ff, wd_pri, be_pri) : pri_tim_ff;
   wire [15:0] nxt_sec_tim  = wr_tim ? merge16(sec_tim_ff, wd_sec, be_sec) : sec_tim_ff;
   wire [7:0]  nxt_irq_line = wr_line ? wd_line : irq_line_ff;

   aft_once_reg #(
      .RESET_VAL (RST_SUBSYSTEM_VENDOR_IDENT)
   ) u_subsystem_vendor_ident (
      .i_clock   (i_clock),
      .i_sys_rst (i_sys_rst),
      .i_wr      (wr_sub && (be_subsystem_vendor_ident != 2'h0)),
      .i_be      (be_subsystem_vendor_ident),
      .i_wdata   (wd_subsystem_vendor_ident),
      .o_value   (subsystem_vendor_ident_val),
      .o_locked  (subsystem_vendor_ident_locked)
   );

   aft_once_reg #(
      .RESET_VAL (RST_SID)
   ) u_sid (
      .i_clock   (i_clock),
      .i_sys_rst (i_sys_rst),
      .i_wr      (wr_sub && (be_sid != 2'h0)),
      .i_be      (be_sid),
      .i_wdata   (wd_sid),
      .o_value   (sid_val),
      .o_locked  (sid_locked)
   );

   // Read data assembly; unmapped dwords read as zero
   wire [31:0] rd_sub = {sid_val, subsystem_vendor_ident_val};
   wire [31:0] rd_cap = {24'h000000, VAL_CAP};
   wire [31:0] rd_int = {16'h0000, VAL_IRQ_PIN_SELECT, irq_line_ff};
   wire [31:0] rd_tim = {sec_tim_ff, pri_tim_ff};
   wire [31:0] rd_word = hit_sub ? rd_sub :
                         hit_cap ? rd_cap :
                         hit_int ? rd_int :
                         hit_tim ? rd_tim : 32'h00000000;

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         pri_tim_ff  <= RST_TIM;
         sec_tim_ff  <= RST_TIM;
         irq_line_ff <= RST_IRQ_ROUTING_LINE;
         rdata_ff    <= 32'h00000000;
      end else begin
         pri_tim_ff  <= nxt_pri_tim;
         sec_tim_ff  <= nxt_sec_tim;
         irq_line_ff <= nxt_irq_line;
         rdata_ff    <= i_cfg_rd ? rd_word : rdata_ff;
      end
   end

   assign o_cfg_rdata = rdata_ff;
   // Reported pin only means something when a channel runs native
   assign o_irq_pin_active = |i_native_mode;

   // Channel decode; serial logic outside reads o_decode_en as well
   wire pri_en = pri_tim_ff[TB_DEC_EN];
   wire sec_en = sec_tim_ff[TB_DEC_EN];
   assign o_decode_en = {sec_en, pri_en};
   wire pri_leg = (i_io_addr[15:3] == PRI_CMD_BASE[15:3]) || (i_io_addr == PRI_CTL_PORT);
   wire sec_leg = (i_io_addr[15:3] == SEC_CMD_BASE[15:3]) || (i_io_addr == SEC_CTL_PORT);
   assign o_pri_hit = pri_en && (i_native_mode[0] ? i_native_hit[0] : pri_leg);
   assign o_sec_hit = sec_en && (i_native_mode[1] ? i_native_hit[1] : sec_leg);

   // Per channel timing resolution
   aft_tim_if pri_tim ();
   aft_tim_if sec_tim ();

   aft_chan_timing u_pri_tim (
      .i_timing    (pri_tim_ff),
      .i_slave_isp (i_slave_timing[SL_PISP_LO +: 2]),
      .i_slave_rct (i_slave_timing[SL_PRCT_LO +: 2]),
      .i_drive     (i_xfer_drive),
      .i_dma       (i_xfer_dma),
      .i_data_port (i_xfer_data_port),
      .o_tim       (pri_tim)
   );

   aft_chan_timing u_sec_tim (
      .i_timing    (sec_tim_ff),
      .i_slave_isp (i_slave_timing[SL_SISP_LO +: 2]),
      .i_slave_rct (i_slave_timing[SL_SRCT_LO +: 2]),
      .i_drive     (i_xfer_drive),
      .i_dma       (i_xfer_dma),
      .i_data_port (i_xfer_data_port),
      .o_tim       (sec_tim)
   );

   wire [2:0] sel_smp = i_xfer_chan ? sec_tim.sample_clks : pri_tim.sample_clks;
   wire [2:0] sel_rec = i_xfer_chan ? sec_tim.recov_clks  : pri_tim.recov_clks;
   wire       sel_rdy = i_xfer_chan ? sec_tim.iordy_en    : pri_tim.iordy_en;
   wire       sel_pf  = i_xfer_chan ? sec_tim.prefetch_en : pri_tim.prefetch_en;
   wire       sel_fst = i_xfer_chan ? sec_tim.fast        : pri_tim.fast;
   wire       sel_en  = i_xfer_chan ? sec_en : pri_en;

   // Cable cycle engine; settings are latched at accept so a config write
   // in mid cycle only affects the next cycle
   wire is_idle   = (state_ff == ST_IDLE);
   wire accept    = is_idle && i_xfer_req && sel_en;
   wire smp_point = (state_ff == ST_STROBE) && (cnt_ff == 3'h0);
   wire rdy_ok    = !rdy_en_ff || i_iordy;
   wire rec_end   = (state_ff == ST_RECOV) && (cnt_ff == 3'h0);

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      unique case (state_ff)
         ST_IDLE: begin
            if (accept) begin
               nxt_state = ST_STROBE;
               nxt_cnt   = sel_smp - 3'h1;
            end
         end
         ST_STROBE: begin
            if (cnt_ff != 3'h0) begin
               nxt_cnt = cnt_ff - 3'h1;
            end else if (rdy_ok) begin
               nxt_state = ST_RECOV;
               nxt_cnt   = rec_ff - 3'h1;
            end else begin
               nxt_state = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (i_iordy) begin
               nxt_state = ST_RECOV;
               nxt_cnt   = rec_ff - 3'h1;
            end
         end
         ST_RECOV: begin
            if (cnt_ff != 3'h0) begin
               nxt_cnt = cnt_ff - 3'h1;
            end else begin
               nxt_state = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         state_ff <= ST_IDLE;
         cnt_ff   <= 3'h0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         smp_ff    <= COMPAT_ISP;
         rec_ff    <= COMPAT_RCT;
         rdy_en_ff <= 1'b0;
         pf_ff     <= 1'b0;
         fast_ff   <= 1'b0;
      end else if (accept) begin
         smp_ff    <= sel_smp;
         rec_ff    <= sel_rec;
         rdy_en_ff <= sel_rdy;
         pf_ff     <= sel_pf;
         fast_ff   <= sel_fst;
      end
   end

   assign o_strobe       = (state_ff == ST_STROBE) || (state_ff == ST_WAIT);
   assign o_busy         = !is_idle;
   assign o_xfer_done    = rec_end;
   assign o_xfer_refused = is_idle && i_xfer_req && !sel_en;
   assign o_prefetch_en  = pf_ff;
   assign o_fast_timing  = fast_ff;

   // Helper counters watched only by the checks below
   logic [2:0] smp_seen_ff;
   logic [2:0] rec_seen_ff;
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         smp_seen_ff <= 3'h0;
         rec_seen_ff <= 3'h0;
      end else begin
         smp_seen_ff <= (state_ff == ST_STROBE) ? smp_seen_ff + 3'h1 : 3'h0;
         rec_seen_ff <= (state_ff == ST_RECOV) ? rec_seen_ff + 3'h1 : 3'h0;
      end
   end

   sequence s_cap_read;
      i_cfg_rd && hit_cap;
   endsequence

   sequence s_int_read;
      i_cfg_rd && hit_int;
   endsequence

   property p_cap_zero;
      @(posedge i_clock) disable iff (i_sys_rst)
      s_cap_read |=> (o_cfg_rdata == 32'h00000000);
   endproperty
   a_cap_zero: assert property (p_cap_zero) else $error("feature head not zero");

   property p_pin_value;
      @(posedge i_clock) disable iff (i_sys_rst)
      s_int_read |=> (o_cfg_rdata[15:8] == VAL_IRQ_PIN_SELECT) && (o_cfg_rdata[7:0] == $past(irq_line_ff));
   endproperty
   a_pin_value: assert property (p_pin_value) else $error("pin or line read wrong");

   property p_line_store;
      @(posedge i_clock) disable iff (i_sys_rst)
      wr_line |=> (irq_line_ff == $past(wd_line));
   endproperty
   a_line_store: assert property (p_line_store) else $error("line not stored");

   property p_tim_reserved;
      @(posedge i_clock) disable iff (i_sys_rst)
      wr_tim |=> (pri_tim_ff[11:10] == 2'h0) && (sec_tim_ff[11:10] == 2'h0);
   endproperty
   a_tim_reserved: assert property (p_tim_reserved) else $error("reserved bits held");

   property p_tim_independent;
      @(posedge i_clock) disable iff (i_sys_rst)
      (wr_tim && be_sec == 2'h0) |=> $stable(sec_tim_ff);
   endproperty
   a_tim_independent: assert property (p_tim_independent) else $error("sec changed");

   property p_decode_gate;
      @(posedge i_clock) disable iff (i_sys_rst)
      !pri_en |-> !o_pri_hit && !(i_xfer_req && !i_xfer_chan && accept);
   endproperty
   a_decode_gate: assert property (p_decode_gate) else $error("decode while disabled");

   property p_native_gate;
      @(posedge i_clock) disable iff (i_sys_rst)
      (i_native_mode[1] && sec_en) |-> (o_sec_hit == i_native_hit[1]);
   endproperty
   a_native_gate: assert property (p_native_gate) else $error("native hit lost");

   property p_sample_len;
      @(posedge i_clock) disable iff (i_sys_rst)
      smp_point |-> (smp_seen_ff + 3'h1 == smp_ff);
   endproperty
   a_sample_len: assert property (p_sample_len) else $error("sample delay wrong");

   property p_recov_len;
      @(posedge i_clock) disable iff (i_sys_rst)
      rec_end |-> (rec_seen_ff + 3'h1 == rec_ff) ##1 is_idle;
   endproperty
   a_recov_len: assert property (p_recov_len) else $error("recovery length wrong");

   property p_no_iordy;
      @(posedge i_clock) disable iff (i_sys_rst)
      (smp_point && !rdy_en_ff) |=> (state_ff == ST_RECOV) && !o_strobe;
   endproperty
   a_no_iordy: assert property (p_no_iordy) else $error("sampled with IORDY off");

   property p_slave_fields;
      @(posedge i_clock) disable iff (i_sys_rst)
      (i_xfer_drive && pri_tim_ff[TB_SEP] && pri_tim.fast) |->
         (pri_tim.sample_clks == isp_clks(i_slave_timing[SL_PISP_LO +: 2]));
   endproperty
   a_slave_fields: assert property (p_slave_fields) else $error("separate timing unused");

   property p_compat_pio;
      @(posedge i_clock) disable iff (i_sys_rst)
      (!i_xfer_dma && !i_xfer_data_port) |-> !pri_tim.fast && !pri_tim.prefetch_en;
   endproperty
   a_compat_pio: assert property (p_compat_pio) else $error("fast on task file");

   property p_accept_latch;
      @(posedge i_clock) disable iff (i_sys_rst)
      accept |=> o_strobe && (o_prefetch_en == $past(sel_pf)) ##1 o_busy;
   endproperty
   a_accept_latch: assert property (p_accept_latch) else $error("accept not latched");
endmodule

// ===== bench/aft_drive_model.sv
// Drive side model: raises IORDY a set number of strobe cycles into each access.
// Assumes the strobe comes from the host cycle timer on the same clock.
`timescale 1ns/1ps
module aft_drive_model (
   // Host side
   input  wire logic       i_clock,
   input  wire logic       i_strobe,
   input  wire logic [3:0] i_wait,
   // Drive side
   output logic            o_iordy
);
   logic [3:0] cnt_ff;
   // Count restarts at each strobe so a slow drive holds every access
   always_ff @(posedge i_clock) cnt_ff <= i_strobe ? cnt_ff + 4'h1 : 4'h0;
   assign o_iordy = (cnt_ff >= i_wait);
endmodule

// ===== bench/tb.sv
// Self-checking bench for the config bank and cable cycle timer.
// Assumes the drive model on the cable side and legacy mode on both channels, except for one primary native decode check.
`timescale 1ns/1ps
module tb;
   import aft_pkg::*;
   logic        i_clock = 1'b0, i_sys_rst = 1'b1, rd = 1'b0, wr = 1'b0, rd_pend = 1'b0;
   logic        req = 1'b0, chn = 1'b0, drv = 1'b0, dp = 1'b0, iordy, strb, busy, done, refd;
   logic [7:0]  adr = 8'h00, slv = 8'h00, rnd = 8'h09;
   logic [3:0]  wt = 4'h0;
   logic [15:0] io = 16'h0000;
   logic [1:0]  nat = 2'h0, dec;
   logic        dma = 1'b0, phit, shit, pina, pfe, fst;
   logic [31:0] wd = 32'h0, rdata, nb = 32'h0;
   logic [31:0] q[$];
   int          n_mismatch = 0, n_compared = 0;
   always #25 i_clock = ~i_clock;
   aft_cfg_top u_aft_cfg_top (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_cfg_rd(rd),
      .i_cfg_wr(wr), .i_cfg_addr(adr), .i_cfg_be(4'hf), .i_cfg_wdata(wd), .o_cfg_rdata(rdata),
      .i_native_mode(nat), .i_slave_timing(slv), .o_irq_pin_active(pina), .o_decode_en(dec),
      .i_io_addr(io), .i_native_hit(nat), .o_pri_hit(phit), .o_sec_hit(shit),
      .i_xfer_req(req), .i_xfer_chan(chn), .i_xfer_drive(drv), .i_xfer_dma(dma),
      .i_xfer_data_port(dp), .i_iordy(iordy), .o_strobe(strb), .o_busy(busy),
      .o_xfer_done(done), .o_xfer_refused(refd), .o_prefetch_en(pfe), .o_fast_timing(fst));
   aft_drive_model u_aft_drive_model (.i_clock(i_clock), .i_strobe(strb), .i_wait(wt),
      .o_iordy(iordy));
   function automatic logic [7:0] lfsr(input logic [7:0] v);
      lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   // Reserved code 11 counts as the shortest delay
   function automatic logic [31:0] sclk(input logic [1:0] c);
      sclk = (c == 2'h3) ? 32'h3 : 32'h5 - c;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t: saw %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic results();
      $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // A read carries its expected value in d
   task automatic cfg(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(negedge i_clock);
      wr = w;
      rd = !w;
      adr = a;
      wd = d;
      if (!w) q.push_back(d);
      @(negedge i_clock);
      wr = 1'b0;
      rd = 1'b0;
   endtask
   task automatic xfer(input logic d, input logic p, input logic [31:0] e);
      int i;
      @(negedge i_clock);
      req = 1'b1;
      drv = d;
      dp = p;
      q.push_back(e);
      @(negedge i_clock);
      req = 1'b0;
      for (i = 0; i < 40 && done !== 1'b1; i++) @(negedge i_clock);
      if (i == 40) begin
         n_mismatch++;
         results();
      end
      @(negedge i_clock);
   endtask
   // Read data and busy length of each cycle are checked against the oldest note
   always @(posedge i_clock) rd_pend <= rd;
   always @(negedge i_clock) begin
      if (rd_pend === 1'b1) chk(rdata, q.pop_front());
      if (busy === 1'b1) nb = nb + 1;
      if (done === 1'b1) begin
         chk(nb, q.pop_front());
         nb = 0;
      end
   end
   initial begin
      int k;
      logic sel;
      logic [1:0] ic;
      logic [31:0] sp, rp;
      repeat (20) @(negedge i_clock);
      i_sys_rst = 1'b0;
      cfg(1'b0, 8'h2c, 32'h0);
      cfg(1'b0, 8'h3c, 32'h0000_0100);
      cfg(1'b0, 8'h40, 32'h0);
      cfg(1'b1, 8'h2c, 32'h1234_5678);
      cfg(1'b1, 8'h2c, 32'haaaa_5555);
      cfg(1'b0, 8'h2c, 32'h1234_5678);
      cfg(1'b1, 8'h34, 32'hffff_ffff);
      cfg(1'b0, 8'h34, 32'h0);
      cfg(1'b1, 8'h3c, 32'hffff_ffa5);
      cfg(1'b0, 8'h3c, 32'h0000_01a5);
      cfg(1'b1, 8'h40, 32'hffff_ffff);
      cfg(1'b0, 8'h40, 32'hf3ff_f3ff);
      io = 16'h01f3;
      #1 chk(phit, 1'b1);
      chk(dec, 2'h3);
      io = 16'h0376;
      #1 chk(shit, 1'b1);
      nat = 2'h1;
      #1 chk(phit, 1'b1);
      chk(pina, 1'b1);
      nat = 2'h0;
      io = 16'h01f3;
      i_sys_rst = 1'b1;
      @(negedge i_clock);
      i_sys_rst = 1'b0;
      cfg(1'b0, 8'h2c, 32'h0);
      #1 chk(phit, 1'b0);
      $display("Config tests done");
      for (k = 0; k < 6; k++) begin
         rnd = lfsr(rnd);
         slv = rnd;
         wt = {1'b0, rnd[6:4]};
         ic = 2'(k % 3);
         sel = k[0] & k[1];
         cfg(1'b1, 8'h40, {16'h0, 1'b1, k[1], ic, 2'b00, rnd[7:6], k[0] ? 8'h30 : 8'h03});
         sp = sel ? sclk(slv[3:2]) : sclk(ic);
         rp = 32'h4 - (sel ? slv[1:0] : rnd[7:6]);
         xfer(k[0], 1'b1, ((sp > wt) ? sp : wt + 1) + rp);
      end
      wt = 4'h0;
      xfer(1'b0, 1'b0, 32'(COMPAT_ISP) + 32'(COMPAT_RCT));
      cfg(1'b1, 8'h40, 32'h0000_8001);
      wt = 4'h8;
      xfer(1'b0, 1'b1, 32'h9);
      chk(fst, 1'b1);
      wt = 4'h0;
      cfg(1'b1, 8'h40, 32'h0000_8006);
      xfer(1'b0, 1'b1, 32'd11);
      chk(pfe, 1'b1);
      chk(fst, 1'b0);
      cfg(1'b1, 8'h40, 32'h0000_8008);
      dma = 1'b1;
      xfer(1'b0, 1'b0, 32'h9);
      chk(fst, 1'b1);
      chk(pfe, 1'b0);
      dma = 1'b0;
      $display("Cable cycle tests done");
      @(negedge i_clock);
      req = 1'b1;
      chn = 1'b1;
      #1 chk(refd, 1'b1);
      @(negedge i_clock);
      req = 1'b0;
      chk(busy, 1'b0);
      $display("Refusal test done");
      results();
   end
endmodule
